// File: amd_asserts.sv
// assertion checker for the addressing mode decoder
`timescale 1ns/10ps
`default_nettype none
`include "amd_consts.vh"
module amd_asserts
(
  // clock, reset, sequencer
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic        start_in,
  input wire logic [15:0] pc_in,
  // memory bus
  input wire logic        mem_rd_out,
  input wire logic        mem_ack_in,
  input wire logic [7:0]  mem_data_in,
  // results
  input wire logic        done_out,
  input wire logic [4:0]  mode_out,
  input wire logic [7:0]  opcode_out,
  input wire logic [15:0] ea_out,
  input wire logic [7:0]  operand_out,
  input wire logic [15:0] next_pc_out,
  input wire logic [2:0]  length_out,
  input wire logic [1:0]  int_mask_out,
  input wire logic        busy_out
);
  logic [15:0] pc0;
  logic [7:0]  last;
  logic [2:0]  acks;
  // start address, last byte taken, bytes taken
  always_ff @(posedge clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      pc0  <= 16'h0000;
      last <= 8'h00;
      acks <= 3'h0;
    end
    else
    begin
      if (start_in && !busy_out)
      begin
        pc0  <= pc_in;
        acks <= 3'h0;
      end
      else if (mem_rd_out && mem_ack_in)
        acks <= acks + 3'h1;
      if (mem_rd_out && mem_ack_in)
        last <= mem_data_in;
    end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ***********
  // properties
  // ***********
  property p_mask_set;
    done_out && opcode_out == `OP_MASK_SET |=> int_mask_out == `MASK_LEVEL_SET;
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask not raised");
  property p_mask_clr;
    done_out && opcode_out == `OP_MASK_CLEAR |=> int_mask_out == `MASK_LEVEL_CLEAR;
  endproperty
  a_mask_clr: assert property (p_mask_clr) else $error("mask not lowered");
  property p_inh_len;
    done_out && mode_out == `AM_INH |-> acks == length_out;
  endproperty
  a_inh_len: assert property (p_inh_len) else $error("inherent byte count");
  property p_imm;
    done_out && mode_out == `AM_IMM |-> operand_out == last && acks == length_out;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate operand");
  property p_dir_s;
    done_out && mode_out == `AM_DIR_S |-> ea_out[15:8] == 8'h00;
  endproperty
  a_dir_s: assert property (p_dir_s) else $error("short direct reach");
  property p_idx0;
    done_out && mode_out == `AM_IDX_0 |-> ea_out[15:8] == 8'h00 && acks == length_out;
  endproperty
  a_idx0: assert property (p_idx0) else $error("no offset index");
  property p_reach;
    done_out && (mode_out == `AM_IDX_S || mode_out == `AM_INDX_S) |-> ea_out <= 16'h01FE;
  endproperty
  a_reach: assert property (p_reach) else $error("short index reach");
  property p_rel;
    done_out && mode_out == `AM_REL_D |->
      ea_out == next_pc_out + {{8{operand_out[7]}}, operand_out};
  endproperty
  a_rel: assert property (p_rel) else $error("branch target");
  property p_next_pc;
    done_out |-> next_pc_out == pc0 + length_out;
  endproperty
  a_next_pc: assert property (p_next_pc) else $error("next pc");
  property p_done;
    $rose(done_out) |=> $fell(done_out);
  endproperty
  a_done: assert property (p_done) else $error("done not a pulse");
endmodule // amd_asserts
bind cpu_addressing_mode_decoder amd_asserts u_amd_asserts
(
  .clk_in, .nrst_in, .start_in, .pc_in, .mem_rd_out, .mem_ack_in, .mem_data_in,
  .done_out, .mode_out, .opcode_out, .ea_out, .operand_out, .next_pc_out,
  .length_out, .int_mask_out, .busy_out
);
`default_nettype wire

// File: amd_consts.vh
// constants for the cpu addressing mode decoder
`ifndef AMD_CONSTS_VH
`define AMD_CONSTS_VH
// prefix bytes
`define PFX_SECOND_INDEX          8'h90
`define PFX_SECOND_INDEX_INDIRECT 8'h91
`define PFX_INDIRECT              8'h92
// addressing mode codes (17 modes)
`define AM_INH      5'h00
`define AM_IMM      5'h01
`define AM_DIR_S    5'h02
`define AM_DIR_L    5'h03
`define AM_IDX_0    5'h04
`define AM_IDX_S    5'h05
`define AM_IDX_L    5'h06
`define AM_IND_S    5'h07
`define AM_IND_L    5'h08
`define AM_INDX_S   5'h09
`define AM_INDX_L   5'h0A
`define AM_REL_D    5'h0B
`define AM_REL_I    5'h0C
`define AM_BIT_D    5'h0D
`define AM_BIT_I    5'h0E
`define AM_BITR_D   5'h0F
`define AM_BITR_I   5'h10
// interrupt mask levels
`define MASK_LEVEL_SET   2'h3
`define MASK_LEVEL_CLEAR 2'h0
// opcodes of the two mask instructions
`define OP_MASK_SET   8'h9B
`define OP_MASK_CLEAR 8'h9A
`endif

// File: amd_mem_model.sv
// byte memory answering the decoder's reads
`timescale 1ns/10ps
`default_nettype none
module amd_mem_model
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // request and wait setting
  input  wire logic        rd_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [3:0]  wait_in,
  // answer
  output logic             ack_out,
  output logic [7:0]       data_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  logic [3:0] cnt;
  // answer after wait_in cycles, junk while not answering
  assign ack_out  = rd_in && (cnt >= wait_in);
  assign data_out = ack_out ? mem[addr_in] : ~last;
  // wait counter per byte
  always_ff @(posedge clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      cnt  <= 4'h0;
      last <= 8'h00;
    end
    else if (ack_out)
    begin
      cnt  <= 4'h0;
      last <= data_out;
    end
    else if (rd_in)
      cnt <= cnt + 4'h1;
endmodule // amd_mem_model
`default_nettype wire

// File: amd_mode_table.v
// opcode to addressing mode lookup
`timescale 1ns/10ps
`default_nettype none
`include "amd_consts.vh"
module amd_mode_table
(
  // opcode and prefix state
  input  wire [7:0] opcode_in,
  input  wire       pfx_ind_in,
  // decoded mode
  output reg  [4:0] mode_out,
  output reg        rmw_out
);
  // ****************************************
  // mode decode by opcode column (high nibble)
  // ****************************************
  // mode from high nibble; prefix turns direct/offset-indexed into indirect forms, no-offset indexed stays
  always @*
  begin
    mode_out = `AM_INH;
    rmw_out  = 1'b0;
    case (opcode_in[7:4])
      4'h0: mode_out = pfx_ind_in ? `AM_BITR_I : `AM_BITR_D;
      4'h1:
      begin
        mode_out = pfx_ind_in ? `AM_BIT_I : `AM_BIT_D;
        rmw_out  = 1'b1;
      end
      4'h2: mode_out = pfx_ind_in ? `AM_REL_I : `AM_REL_D;
      4'h3:
      begin
        mode_out = pfx_ind_in ? `AM_IND_S : `AM_DIR_S;
        rmw_out  = 1'b1;
      end
      4'h4, 4'h5, 4'h8, 4'h9: mode_out = `AM_INH;
      4'h6:
      begin
        mode_out = pfx_ind_in ? `AM_INDX_S : `AM_IDX_S;
        rmw_out  = 1'b1;
      end
      4'h7:
      begin
        mode_out = `AM_IDX_0;
        rmw_out  = 1'b1;
      end
      4'hA: mode_out = `AM_IMM;
      4'hB: mode_out = pfx_ind_in ? `AM_IND_S : `AM_DIR_S;
      4'hC: mode_out = pfx_ind_in ? `AM_IND_L : `AM_DIR_L;
      4'hD: mode_out = pfx_ind_in ? `AM_INDX_L : `AM_IDX_L;
      4'hE: mode_out = pfx_ind_in ? `AM_INDX_S : `AM_IDX_S;
      4'hF: mode_out = `AM_IDX_0;
      default: mode_out = `AM_INH;
    endcase
  end
endmodule // amd_mode_table
`default_nettype wire

// File: cpu_addressing_mode_decoder.v
// fetch sequencer and effective address generator
`timescale 1ns/10ps
`default_nettype none
`include "amd_consts.vh"
module cpu_addressing_mode_decoder
(
  // clock and reset
  input  wire        clk_in,
  input  wire        nrst_in,
  // sequencer control
  input  wire        start_in,
  input  wire [15:0] pc_in,
  input  wire [7:0]  index_x_in,
  input  wire [7:0]  index_y_in,
  // memory bus
  output reg  [15:0] mem_addr_out,
  output wire        mem_rd_out,
  input  wire        mem_ack_in,
  input  wire [7:0]  mem_data_in,
  // results
  output reg         done_out,
  output reg  [4:0]  mode_out,
  output reg  [7:0]  opcode_out,
  output reg  [15:0] ea_out,
  output reg  [7:0]  operand_out,
  output reg  [15:0] next_pc_out,
  output reg  [2:0]  length_out,
  output reg         rmw_out,
  output reg  [1:0]  int_mask_out,
  output wire        busy_out
);
  // ****************************************
  // states
  // ****************************************
  localparam ST_IDLE  = 3'h0;
  localparam ST_OPC   = 3'h1;
  localparam ST_OPND  = 3'h2;
  localparam ST_PTR   = 3'h3;
  localparam ST_OFS   = 3'h4;
  localparam ST_DONE  = 3'h5;

  // ****************************************
  // registers
  // ****************************************
  // sequencer state, fetch pointer, prefixes, captured fields
  reg  [2:0]  state;
  reg  [15:0] fetch_pc;
  reg  [7:0]  opc;
  reg         pfx_y;
  reg         pfx_ind;
  reg         pfx_iy;
  reg  [1:0]  opnd_left;
  reg  [1:0]  ptr_left;
  reg  [15:0] word_acc;
  reg  [15:0] ptr_base;
  reg  [2:0]  len;
  reg  [4:0]  mode;
  reg         rmw;
  wire [4:0]  tbl_mode;
  wire        tbl_rmw;

  // ****************************************
  // bus strobes
  // ****************************************
  // a byte is wanted in every fetch state
  assign mem_rd_out = (state == ST_OPC) || (state == ST_OPND) ||
                      (state == ST_PTR) || (state == ST_OFS);
  assign busy_out   = (state != ST_IDLE);

  // ****************************************
  // mode table
  // ****************************************
  // opcode column lookup, prefix aware
  amd_mode_table u_table
  (
    .opcode_in  (mem_data_in),
    .pfx_ind_in (pfx_ind),
    .mode_out   (tbl_mode),
    .rmw_out    (tbl_rmw)
  );

  // ****************************************
  // per-mode operand byte counts
  // ****************************************
  // bytes after opcode, pointer bytes to read
  reg [1:0] n_opnd;
  reg [1:0] n_ptr;
  reg       uses_idx;
  always @*
  begin
    n_opnd   = 2'h0;
    n_ptr    = 2'h0;
    uses_idx = 1'b0;
    case (tbl_mode)
      `AM_INH:    n_opnd = 2'h0;
      `AM_IMM:    n_opnd = 2'h1;
      `AM_DIR_S:  n_opnd = 2'h1;
      `AM_DIR_L:  n_opnd = 2'h2;
      `AM_IDX_0:  uses_idx = 1'b1;
      `AM_IDX_S:
      begin
        n_opnd   = 2'h1;
        uses_idx = 1'b1;
      end
      `AM_IDX_L:
      begin
        n_opnd   = 2'h2;
        uses_idx = 1'b1;
      end
      `AM_IND_S:
      begin
        n_opnd = 2'h1;
        n_ptr  = 2'h1;
      end
      `AM_IND_L:
      begin
        n_opnd = 2'h1;
        n_ptr  = 2'h2;
      end
      `AM_INDX_S:
      begin
        n_opnd   = 2'h1;
        n_ptr    = 2'h1;
        uses_idx = 1'b1;
      end
      `AM_INDX_L:
      begin
        n_opnd   = 2'h1;
        n_ptr    = 2'h2;
        uses_idx = 1'b1;
      end
      `AM_REL_D:  n_opnd = 2'h1;
      `AM_REL_I:
      begin
        n_opnd = 2'h1;
        n_ptr  = 2'h1;
      end
      `AM_BIT_D:  n_opnd = 2'h1;
      `AM_BIT_I:
      begin
        n_opnd = 2'h1;
        n_ptr  = 2'h1;
      end
      `AM_BITR_D: n_opnd = 2'h2;
      `AM_BITR_I:
      begin
        n_opnd = 2'h2;
        n_ptr  = 2'h1;
      end
      default:    n_opnd = 2'h0;
    endcase
  end

  // selected index: prefix 90 or 91 selects second index
  wire [7:0] idx_sel = (pfx_y || pfx_iy) ? index_y_in : index_x_in;

  // ****************************************
  // sequencer
  // ****************************************
  // walks prefixes and opcode, operand bytes, pointer bytes, then publishes
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state        <= ST_IDLE;
      fetch_pc     <= 16'h0000;
      opc          <= 8'h00;
      pfx_y        <= 1'b0;
      pfx_ind      <= 1'b0;
      pfx_iy       <= 1'b0;
      opnd_left    <= 2'h0;
      ptr_left     <= 2'h0;
      word_acc     <= 16'h0000;
      ptr_base     <= 16'h0000;
      len          <= 3'h0;
      mode         <= 5'h00;
      rmw          <= 1'b0;
      mem_addr_out <= 16'h0000;
      done_out     <= 1'b0;
      mode_out     <= 5'h00;
      opcode_out   <= 8'h00;
      ea_out       <= 16'h0000;
      operand_out  <= 8'h00;
      next_pc_out  <= 16'h0000;
      length_out   <= 3'h0;
      rmw_out      <= 1'b0;
      int_mask_out <= `MASK_LEVEL_SET;
    end
    else
    begin
      done_out <= 1'b0;
      case (state)
        // capture start address, clear prefixes
        ST_IDLE:
        begin
          if (start_in)
          begin
            fetch_pc     <= pc_in;
            mem_addr_out <= pc_in;
            pfx_y        <= 1'b0;
            pfx_ind      <= 1'b0;
            pfx_iy       <= 1'b0;
            len          <= 3'h0;
            word_acc     <= 16'h0000;
            state        <= ST_OPC;
          end
        end
        // prefix or opcode byte
        ST_OPC:
        begin
          if (mem_ack_in)
          begin
            fetch_pc     <= fetch_pc + 16'h0001;
            mem_addr_out <= fetch_pc + 16'h0001;
            len          <= len + 3'h1;
            if (mem_data_in == `PFX_SECOND_INDEX)
              pfx_y <= 1'b1;
            else if (mem_data_in == `PFX_INDIRECT)
              pfx_ind <= 1'b1;
            else if (mem_data_in == `PFX_SECOND_INDEX_INDIRECT)
            begin
              pfx_iy  <= 1'b1;
              pfx_ind <= 1'b1;
            end
            else
            begin
              opc       <= mem_data_in;
              mode      <= tbl_mode;
              rmw       <= tbl_rmw;
              opnd_left <= n_opnd;
              ptr_left  <= n_ptr;
              // no-offset indexed: index alone is the address
              ptr_base  <= uses_idx ? {8'h00, idx_sel} : 16'h0000;
              if (mem_data_in == `OP_MASK_SET)
                int_mask_out <= `MASK_LEVEL_SET;
              else if (mem_data_in == `OP_MASK_CLEAR)
                int_mask_out <= `MASK_LEVEL_CLEAR;
              state <= (n_opnd == 2'h0) ? ST_DONE : ST_OPND;
            end
          end
        end
        ST_OPND:
        begin
          if (mem_ack_in)
          begin
            fetch_pc     <= fetch_pc + 16'h0001;
            mem_addr_out <= fetch_pc + 16'h0001;
            len          <= len + 3'h1;
            // bit-relative: first byte is address, last is jump offset
            if ((mode == `AM_BITR_D || mode == `AM_BITR_I) && opnd_left == 2'h1)
              operand_out <= mem_data_in;
            else
              word_acc <= {word_acc[7:0], mem_data_in};
            if (mode == `AM_IMM || mode == `AM_REL_D)
              operand_out <= mem_data_in;
            opnd_left <= opnd_left - 2'h1;
            if (opnd_left == 2'h1)
            begin
              if (ptr_left != 2'h0)
              begin
                // pointer lives in page zero
                mem_addr_out <= {8'h00, ((mode == `AM_BITR_I) ? word_acc[7:0]
                                : mem_data_in)};
                state        <= ST_PTR;
              end
              else
                state <= ST_DONE;
            end
          end
        end
        // pointer bytes from page zero, high byte first
        ST_PTR:
        begin
          if (mem_ack_in)
          begin
            word_acc     <= {word_acc[7:0], mem_data_in};
            mem_addr_out <= mem_addr_out + 16'h0001;
            ptr_left     <= ptr_left - 2'h1;
            if (ptr_left == 2'h1)
            begin
              if (mode == `AM_REL_I)
                operand_out <= mem_data_in;
              state <= ST_DONE;
            end
          end
        end
        // publish results and effective address
        ST_DONE:
        begin
          done_out    <= 1'b1;
          mode_out    <= mode;
          opcode_out  <= opc;
          rmw_out     <= rmw;
          length_out  <= len;
          next_pc_out <= fetch_pc;
          case (mode)
            `AM_IDX_0:
              ea_out <= ptr_base;
            `AM_IDX_S, `AM_INDX_S:
              ea_out <= {8'h00, word_acc[7:0]} + {8'h00, idx_sel};
            `AM_IDX_L, `AM_INDX_L:
              ea_out <= word_acc + {8'h00, idx_sel};
            `AM_DIR_S, `AM_IND_S, `AM_BIT_D, `AM_BIT_I:
              ea_out <= {8'h00, word_acc[7:0]};
            `AM_DIR_L, `AM_IND_L:
              ea_out <= word_acc;
            `AM_BITR_D, `AM_BITR_I:
              ea_out <= {8'h00, word_acc[7:0]};
            `AM_REL_D, `AM_REL_I:
              ea_out <= fetch_pc + {{8{operand_out[7]}}, operand_out};
            default:
              ea_out <= 16'h0000;
          endcase
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // cpu_addressing_mode_decoder
`default_nettype wire

// File: tb_top.sv
// testbench for the addressing mode decoder
`timescale 1ns/10ps
`default_nettype none
`include "amd_consts.vh"
module tb_top;
  logic clk_in = 1'b0, nrst_in = 1'b0, start_in = 1'b0;
  logic [15:0] pc_in = 16'h0000;
  logic [7:0]  index_x_in = 8'h00, index_y_in = 8'h00;
  logic [3:0]  wait_in = 4'h0;
  logic [15:0] mem_addr_out, ea_out, next_pc_out;
  logic [7:0]  mem_data_in, opcode_out, operand_out;
  logic [4:0]  mode_out;
  logic [2:0]  length_out;
  logic [1:0]  int_mask_out;
  logic        mem_rd_out, mem_ack_in, done_out, rmw_out, busy_out;
  int          bad_count = 0, cmp_count = 0;
  always #2.5 clk_in = ~clk_in;
  cpu_addressing_mode_decoder u_cpu_addressing_mode_decoder
  (
    .clk_in, .nrst_in, .start_in, .pc_in, .index_x_in, .index_y_in, .mem_addr_out,
    .mem_rd_out, .mem_ack_in, .mem_data_in, .done_out, .mode_out, .opcode_out,
    .ea_out, .operand_out, .next_pc_out, .length_out, .rmw_out, .int_mask_out,
    .busy_out
  );
  amd_mem_model u_amd_mem_model
  (
    .clk_in, .nrst_in, .rd_in(mem_rd_out), .addr_in(mem_addr_out), .wait_in,
    .ack_out(mem_ack_in), .data_out(mem_data_in)
  );
  // ***********
  // tasks
  // ***********
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic put(input logic [15:0] a, input logic [7:0] b0, b1, b2);
    u_amd_mem_model.mem[a] = b0;
    u_amd_mem_model.mem[a + 16'h1] = b1;
    u_amd_mem_model.mem[a + 16'h2] = b2;
  endtask
  // start one decode and compare its results
  task automatic run(input logic [15:0] pc, input logic [4:0] md, input logic [2:0] len,
                     input logic [15:0] ea, input logic ce);
    int n;
    @(posedge clk_in);
    pc_in <= pc;
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    @(negedge clk_in);
    chk("busy", {15'h0, busy_out}, 16'h1);
    for (n = 0; n < 80 && done_out !== 1'b1; n++)
      @(negedge clk_in);
    chk("done", {15'h0, done_out}, 16'h1);
    chk("idle", {15'h0, busy_out}, 16'h0);
    chk("mode", {11'h0, mode_out}, {11'h0, md});
    chk("length", {13'h0, length_out}, {13'h0, len});
    chk("next pc", next_pc_out, pc + len);
    if (ce)
      chk("ea", ea_out, ea);
  endtask
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ***********
  // scenarios
  // ***********
  task automatic t_inh();
    chk("mask at reset", {14'h0, int_mask_out}, 16'h3);
    put(16'h0100, 8'h9A, 8'h9B, 8'h00);
    run(16'h0100, `AM_INH, 3'h1, 16'h0, 1'b0);
    @(negedge clk_in);
    chk("mask", {14'h0, int_mask_out}, 16'h0);
    chk("opcode", {8'h0, opcode_out}, 16'h009A);
    run(16'h0101, `AM_INH, 3'h1, 16'h0, 1'b0);
    @(negedge clk_in);
    chk("mask", {14'h0, int_mask_out}, 16'h3);
    $display("test inherent done");
  endtask
  task automatic t_imm_dir();
    wait_in <= 4'h3;
    put(16'h0200, 8'hA1, 8'h5C, 8'hB1);
    put(16'h0203, 8'h80, 8'hC1, 8'h12);
    put(16'h0206, 8'h34, 8'h31, 8'h7F);
    run(16'h0200, `AM_IMM, 3'h2, 16'h0, 1'b0);
    chk("operand", {8'h0, operand_out}, 16'h005C);
    wait_in <= 4'h0;
    run(16'h0202, `AM_DIR_S, 3'h2, 16'h0080, 1'b1);
    chk("rmw", {15'h0, rmw_out}, 16'h0);
    run(16'h0204, `AM_DIR_L, 3'h3, 16'h1234, 1'b1);
    run(16'h0207, `AM_DIR_S, 3'h2, 16'h007F, 1'b1);
    chk("rmw", {15'h0, rmw_out}, 16'h1);
    $display("test immediate and direct done");
  endtask
  task automatic t_ind();
    put(16'h0040, 8'hC7, 8'h00, 8'hAB);
    put(16'h0043, 8'hCD, 8'h00, 8'h00);
    put(16'h0400, 8'h92, 8'hB1, 8'h40);
    put(16'h0403, 8'h92, 8'hC1, 8'h42);
    run(16'h0400, `AM_IND_S, 3'h3, 16'h00C7, 1'b1);
    run(16'h0403, `AM_IND_L, 3'h3, 16'hABCD, 1'b1);
    $display("test indirect done");
  endtask
  task automatic t_idx();
    @(posedge clk_in);
    index_x_in <= 8'hFF;
    index_y_in <= 8'h0F;
    put(16'h0020, 8'hFF, 8'h00, 8'h00);
    put(16'h0500, 8'hF1, 8'hE1, 8'hFF);
    put(16'h0503, 8'hD1, 8'h12, 8'h34);
    put(16'h0506, 8'h90, 8'hF1, 8'h92);
    put(16'h0509, 8'hE1, 8'h20, 8'h91);
    put(16'h050C, 8'hE1, 8'h20, 8'h00);
    run(16'h0500, `AM_IDX_0, 3'h1, 16'h00FF, 1'b1);
    run(16'h0501, `AM_IDX_S, 3'h2, 16'h01FE, 1'b1);
    run(16'h0503, `AM_IDX_L, 3'h3, 16'h1333, 1'b1);
    run(16'h0506, `AM_IDX_0, 3'h2, 16'h000F, 1'b1);
    run(16'h0508, `AM_INDX_S, 3'h3, 16'h01FE, 1'b1);
    run(16'h050B, `AM_INDX_S, 3'h3, 16'h010E, 1'b1);
    $display("test indexed done");
  endtask
  task automatic t_rel();
    put(16'h0600, 8'h21, 8'hFE, 8'h21);
    put(16'h0603, 8'h05, 8'h00, 8'h00);
    run(16'h0600, `AM_REL_D, 3'h2, 16'h0600, 1'b1);
    run(16'h0602, `AM_REL_D, 3'h2, 16'h0609, 1'b1);
    $display("test relative done");
  endtask
  task automatic t_bit();
    put(16'h0050, 8'h66, 8'hAB, 8'hF0);
    put(16'h0800, 8'h11, 8'h3C, 8'h92);
    put(16'h0803, 8'h11, 8'h50, 8'h01);
    put(16'h0806, 8'h44, 8'h10, 8'h92);
    put(16'h0809, 8'h01, 8'h51, 8'h7E);
    put(16'h080C, 8'h92, 8'h21, 8'h52);
    put(16'h080F, 8'h91, 8'hD1, 8'h50);
    run(16'h0800, `AM_BIT_D, 3'h2, 16'h003C, 1'b1);
    chk("opcode", {8'h0, opcode_out}, 16'h0011);
    chk("rmw", {15'h0, rmw_out}, 16'h1);
    run(16'h0802, `AM_BIT_I, 3'h3, 16'h0066, 1'b1);
    run(16'h0805, `AM_BITR_D, 3'h3, 16'h0044, 1'b1);
    chk("bit jump offset", {8'h0, operand_out}, 16'h0010);
    run(16'h0808, `AM_BITR_I, 3'h4, 16'h00AB, 1'b1);
    chk("bit jump offset", {8'h0, operand_out}, 16'h007E);
    run(16'h080C, `AM_REL_I, 3'h3, 16'h07FF, 1'b1);
    chk("offset", {8'h0, operand_out}, 16'h00F0);
    run(16'h080F, `AM_INDX_L, 3'h3, 16'h66BA, 1'b1);
    $display("test bit and indirect forms done");
  endtask
  task automatic t_rst();
    put(16'h0700, 8'h9A, 8'h9A, 8'h00);
    run(16'h0700, `AM_INH, 3'h1, 16'h0, 1'b0);
    @(posedge clk_in);
    wait_in <= 4'h5;
    pc_in <= 16'h0701;
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    @(posedge clk_in);
    nrst_in <= 1'b0;
    @(negedge clk_in);
    chk("busy in reset", {15'h0, busy_out}, 16'h0);
    chk("done in reset", {15'h0, done_out}, 16'h0);
    chk("mask in reset", {14'h0, int_mask_out}, 16'h3);
    @(posedge clk_in);
    nrst_in <= 1'b1;
    wait_in <= 4'h0;
    run(16'h0701, `AM_INH, 3'h1, 16'h0, 1'b0);
    chk("mask", {14'h0, int_mask_out}, 16'h0);
    $display("test reset done");
  endtask
  // watchdog
  initial
  begin
    #20000;
    bad_count++;
    end_sim();
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_inh();
    t_imm_dir();
    t_ind();
    t_idx();
    t_rel();
    t_bit();
    t_rst();
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
